// ### hdl/cspsw_top.sv
// Drive status word builder for cyclic synchronous position mode
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "cspsw_params.svh"
module cspsw_top
  import cspsw_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [3:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic [31:0]           reg_rdata,
  input  wire logic [6:0]       drive_state_bits,
  input  wire logic             motor_excited,
  input  wire logic             torque_limit_reached,
  input  wire logic [31:0]      position_deviation,
  input  wire cspsw_alarm_clr_t alarm_clr,
  input  wire cspsw_limits_t    limits,
  input  wire logic             stop_input,
  input  wire logic             init_done,
  input  wire logic             info_present,
  input  wire logic             main_power,
  output logic                  target_accept,
  output logic [15:0]           drive_status_word
);
  logic [15:0] ctrl_q;
  logic [15:0] ctrl_d;
  logic [31:0] window_q;
  logic [31:0] window_d;
  logic [15:0] status_q;
  logic [15:0] status_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        remote_q;
  logic        remote_d;
  logic        follow_err;
  logic        int_limit;
  logic        op_enabled;
  logic        halt;

  cspsw_follow_err u_fe (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .deviation  (position_deviation),
    .window     (window_q),
    .alarm_clr  (alarm_clr),
    .follow_err (follow_err)
  );

  // Register file: control word from master, following error window
  always_comb begin
    ctrl_d   = ctrl_q;
    window_d = window_q;
    rdata_d  = 32'h0000_0000;
    if (reg_wr) begin
      case (reg_addr)
        `CSPSW_ADDR_CTRL:      ctrl_d   = reg_wdata[15:0];
        `CSPSW_ADDR_FE_WINDOW: window_d = reg_wdata;
        default:               ctrl_d   = ctrl_q;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `CSPSW_ADDR_STATUS:    rdata_d = {16'h0000, status_q};
        `CSPSW_ADDR_CTRL:      rdata_d = {16'h0000, ctrl_q};
        `CSPSW_ADDR_FE_WINDOW: rdata_d = window_q;
        `CSPSW_ADDR_DEVIATION: rdata_d = position_deviation;
        default:               rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_q   <= `CSPSW_CTRL_RESET;
      window_q <= `CSPSW_WINDOW_RESET;
      rdata_q  <= 32'h0000_0000;
    end else begin
      ctrl_q   <= ctrl_d;
      window_q <= window_d;
      rdata_q  <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // Status word assembly
  always_comb begin
    halt       = ctrl_q[`CSPSW_BIT_HALT];
    int_limit  = |limits;
    op_enabled = (drive_state_bits & `CSPSW_STATE_MASK) == `CSPSW_STATE_OP_ENABLED;
    // Remote is sticky: once initialized it stays set until reset
    remote_d   = remote_q | init_done;
    status_d   = 16'h0000;
    status_d[6:0]                  = drive_state_bits;
    status_d[`CSPSW_BIT_TLR]       = torque_limit_reached;
    status_d[`CSPSW_BIT_FOLLOW_ERR] = follow_err;
    status_d[`CSPSW_BIT_TGT_IGNORED] = op_enabled && motor_excited
                                     && !halt && !stop_input && !int_limit;
    status_d[`CSPSW_BIT_INT_LIMIT] = int_limit;
    status_d[`CSPSW_BIT_REMOTE]    = remote_q;
    status_d[`CSPSW_BIT_WARNING]   = info_present;
    status_d[`CSPSW_BIT_VOLTAGE]   = main_power;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status_q <= 16'h0000;
      remote_q <= 1'b0;
    end else begin
      status_q <= status_d;
      remote_q <= remote_d;
    end
  end

  assign drive_status_word = status_q;
  // Target positions are taken only while bit 12 is set
  assign target_accept = status_q[`CSPSW_BIT_TGT_IGNORED];

  torque_bit_a: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 drive_status_word[15] == $past(torque_limit_reached)) else $error("bit 15 wrong");
  follow_bit_a: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 drive_status_word[13] == $past(follow_err)) else $error("bit 13 wrong");
  target_off_a: assert property (@(posedge sys_clk) disable iff (rst)
    !motor_excited || !op_enabled |=> !drive_status_word[12]) else $error("bit 12 set");
  halt_block_a: assert property (@(posedge sys_clk) disable iff (rst)
    halt || stop_input || int_limit |=> !drive_status_word[12]) else $error("bit 12 on halt");
  limit_bit_a: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 drive_status_word[11] == $past(|limits)) else $error("bit 11 wrong");
  remote_bit_a: assert property (@(posedge sys_clk) disable iff (rst)
    init_done |=> ##1 drive_status_word[9]) else $error("remote not set");
  warn_bit_a: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 drive_status_word[7] == $past(info_present)) else $error("bit 7 wrong");
  volt_bit_a: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 drive_status_word[4] == $past(main_power)) else $error("bit 4 wrong");
  unused_bits_a: assert property (@(posedge sys_clk) disable iff (rst)
    drive_status_word[14] == 1'b0 && drive_status_word[10] == 1'b0
    && drive_status_word[8] == 1'b0) else $error("unused bit set");
endmodule

// ### hdl/cspsw_params.svh
// Constants for the position mode drive status word builder
// Functional notes
// - Bit 15 follows torque limit reached
// - Bit 13 sets on deviation over window
// - Bit 13 clears only on alarm 10h/30h clear
// - Bit 12 zero unless enabled and excited
// - Bit 12 zero on halt, stop, limit
// - Bit 11 is OR of limit functions
// - Bit 9 set after initialization done
// - Bit 4 follows main power applied
`ifndef CSPSW_PARAMS_SVH
`define CSPSW_PARAMS_SVH
`define CSPSW_ADDR_STATUS      4'h0
`define CSPSW_ADDR_CTRL        4'h1
`define CSPSW_ADDR_FE_WINDOW   4'h2
`define CSPSW_ADDR_DEVIATION   4'h3
`define CSPSW_BIT_TLR          15
`define CSPSW_BIT_FOLLOW_ERR   13
`define CSPSW_BIT_TGT_IGNORED  12
`define CSPSW_BIT_INT_LIMIT    11
`define CSPSW_BIT_REMOTE       9
`define CSPSW_BIT_WARNING      7
`define CSPSW_BIT_VOLTAGE      4
`define CSPSW_BIT_HALT         8
`define CSPSW_ALARM_DEVIATION  8'h10
`define CSPSW_ALARM_OVERLOAD   8'h30
`define CSPSW_CTRL_RESET       16'h0000
`define CSPSW_WINDOW_RESET     32'h0000_0000
`define CSPSW_STATE_OP_ENABLED 7'h37
`define CSPSW_STATE_MASK       7'h6f
`endif

// ### hdl/cspsw_pkg.sv
// Types shared by the status word builder
package cspsw_pkg;
  typedef struct packed {
    logic fw_sensor;
    logic rv_sensor;
    logic fw_block;
    logic rv_block;
    logic soft_limit;
    logic mech_limit;
  } cspsw_limits_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] code;
  } cspsw_alarm_clr_t;

  typedef enum logic [1:0] {
    CSPSW_FE_IDLE  = 2'b00,
    CSPSW_FE_ERROR = 2'b01
  } cspsw_fe_state_t;
endpackage

// ### hdl/cspsw_follow_err.sv
// Following error flag with alarm-clear based release
`timescale 1ns/1ps
`include "cspsw_params.svh"
module cspsw_follow_err
  import cspsw_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [31:0]      deviation,
  input  wire logic [31:0]      window,
  input  wire cspsw_alarm_clr_t alarm_clr,
  output logic                  follow_err
);
  cspsw_fe_state_t state_q;
  cspsw_fe_state_t state_d;
  logic            over;
  logic            rel;

  function automatic logic [31:0] abs32(input logic [31:0] v);
    abs32 = v[31] ? (~v + 32'h0000_0001) : v;
  endfunction

  always_comb begin
    over = abs32(deviation) > window;
    rel  = alarm_clr.valid && (alarm_clr.code == `CSPSW_ALARM_DEVIATION ||
                               alarm_clr.code == `CSPSW_ALARM_OVERLOAD);
    state_d = state_q;
    case (state_q)
      CSPSW_FE_IDLE: begin
        if (over) begin
          state_d = CSPSW_FE_ERROR;
        end
      end
      CSPSW_FE_ERROR: begin
        // A fresh excess in the clear cycle keeps the flag set
        if (rel && !over) begin
          state_d = CSPSW_FE_IDLE;
        end
      end
      default: state_d = CSPSW_FE_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= CSPSW_FE_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign follow_err = (state_q == CSPSW_FE_ERROR);

  fe_sets_a: assert property (@(posedge sys_clk) disable iff (rst)
    over |=> follow_err) else $error("following error not set");
  fe_holds_a: assert property (@(posedge sys_clk) disable iff (rst)
    follow_err && !rel |=> follow_err) else $error("following error dropped");
endmodule

// ### tb/cspsw_master_model.sv
// Fieldbus master model: register writes and reads on the plain port
`timescale 1ns/1ps
module cspsw_master_model (
  input  wire logic        sys_clk,
  output logic [3:0]       reg_addr,
  output logic [31:0]      reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [31:0] reg_rdata
);
  initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;

  // Halt request and release both travel as plain control writes
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe, so take them then
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
endmodule

// ### tb/csp_status_word_builder_test.sv
// Self-checking bench for the status word builder
`timescale 1ns/1ps
`include "cspsw_params.svh"
module csp_status_word_builder_test import cspsw_pkg::*;;
  logic             sys_clk, reg_wr, reg_rd, motor_excited, torque_limit_reached;
  logic             stop_input, init_done, info_present, main_power, target_accept;
  logic             rst = 1'b1, halt = 1'b0, fe = 1'b0, rem = 1'b0;
  logic [3:0]       reg_addr;
  logic [31:0]      reg_wdata, reg_rdata, position_deviation, r, d;
  logic [6:0]       drive_state_bits;
  logic [15:0]      drive_status_word;
  cspsw_alarm_clr_t alarm_clr;
  cspsw_limits_t    limits;
  int               seed = 10160, error_cnt = 0, cmp_count = 0, i, j;

  cspsw_top i_cspsw_top (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .drive_state_bits(drive_state_bits), .motor_excited(motor_excited),
    .torque_limit_reached(torque_limit_reached), .position_deviation(position_deviation),
    .alarm_clr(alarm_clr), .limits(limits), .stop_input(stop_input), .init_done(init_done),
    .info_present(info_present), .main_power(main_power), .target_accept(target_accept),
    .drive_status_word(drive_status_word));
  cspsw_master_model i_cspsw_master_model (.sys_clk(sys_clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  function automatic logic [15:0] exp_sw();
    logic lim;
    logic ok;
    lim = |limits;
    ok = ((drive_state_bits & `CSPSW_STATE_MASK) == `CSPSW_STATE_OP_ENABLED) && motor_excited
         && !halt && !stop_input && !lim;
    exp_sw = {torque_limit_reached, 1'b0, fe, ok, lim, 1'b0, rem, 1'b0, info_present,
              drive_state_bits[6:5], main_power, drive_state_bits[3:0]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Three edges cover the slowest path (two cycles) with margin
  task automatic settle();
    logic [15:0] e;
    repeat (3) @(posedge sys_clk);
    #1 e = exp_sw();
    chk(32'(drive_status_word), 32'(e));
    chk(32'(target_accept), 32'(e[12]));
  endtask

  task automatic pulse(input logic [7:0] code);
    @(posedge sys_clk);
    alarm_clr <= '{1'b1, code};
    @(posedge sys_clk);
    alarm_clr <= '0;
  endtask

  task automatic end_of_test();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    {drive_state_bits, motor_excited, torque_limit_reached, position_deviation, alarm_clr,
     limits, stop_input, init_done, info_present, main_power} = '0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    for (i = 0; i < 160; i++) begin
      r = $random(seed);
      if (r[22:20] == 3'h0) begin
        halt = ~halt;
        i_cspsw_master_model.wr(`CSPSW_ADDR_CTRL, 32'(halt) << `CSPSW_BIT_HALT);
      end
      @(posedge sys_clk);
      // Biased toward the operation enabled code, though the masked compare never matches it, so the accept bit stays low
      drive_state_bits <= r[1] ? `CSPSW_STATE_OP_ENABLED : r[8:2];
      motor_excited <= r[9] | r[10];
      stop_input <= r[11] & r[12];
      limits <= r[13] ? cspsw_limits_t'(r[19:14]) : '0;
      {torque_limit_reached, info_present, main_power} <= r[25:23];
      init_done <= i inside {[60:90]};
      rem = rem | (i >= 60);
      settle();
    end
    i_cspsw_master_model.rd(`CSPSW_ADDR_STATUS, d);
    chk(d, {16'h0000, exp_sw()});
    i_cspsw_master_model.rd(4'hf, d);
    chk(d, 32'h0000_0000);
    i_cspsw_master_model.wr(`CSPSW_ADDR_FE_WINDOW, 32'h0000_0064);
    i_cspsw_master_model.rd(`CSPSW_ADDR_FE_WINDOW, d);
    chk(d, 32'h0000_0064);
    // Control word read-back carries the last halt request in bit 8
    i_cspsw_master_model.rd(`CSPSW_ADDR_CTRL, d);
    chk(d, 32'(halt) << `CSPSW_BIT_HALT);
    // Read data stand one cycle only, then return to zero
    @(posedge sys_clk);
    #1 chk(reg_rdata, 32'h0000_0000);
    for (j = 0; j < 2; j++) begin
      @(posedge sys_clk);
      position_deviation <= j ? 32'hffff_ff9b : 32'h0000_0065;
      fe = 1'b1;
      settle();
      pulse(j ? `CSPSW_ALARM_OVERLOAD : `CSPSW_ALARM_DEVIATION);
      settle();
      @(posedge sys_clk);
      position_deviation <= 32'h0000_0064;
      pulse(8'h20);
      settle();
      pulse(j ? `CSPSW_ALARM_OVERLOAD : `CSPSW_ALARM_DEVIATION);
      fe = 1'b0;
      settle();
    end
    i_cspsw_master_model.rd(`CSPSW_ADDR_DEVIATION, d);
    chk(d, 32'h0000_0064);
    end_of_test();
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    error_cnt++;
    end_of_test();
  end
endmodule
